//--- umpi_top.sv
// two-channel serial and modem pin block with a wishbone register slave
//
// The address map and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "umpi_regs.svh"
module umpi_top #(
	parameter int CLK_HZ  = `UMPI_CLK_HZ,
	parameter int BAUD_HZ = `UMPI_BAUD_HZ
) (
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rstn,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// serial data
	input  wire logic        serial_in_ch_a,
	input  wire logic        serial_in_ch_b,
	output logic             serial_out_ch_a,
	output logic             serial_out_ch_b,
	// modem pins, index 0 is channel a
	output logic      [1:0]  request_to_send_n,
	input  wire logic [1:0]  clear_to_send_n,
	output logic      [1:0]  terminal_ready_n,
	input  wire logic [1:0]  data_set_ready_n,
	input  wire logic [1:0]  carrier_detect_n,
	input  wire logic [1:0]  ring_indicator_n,
	output logic      [1:0]  aux_output_two_n,
	// channel irq pin, three-state
	output logic      [1:0]  channel_irq,
	output logic      [1:0]  channel_irq_oe,
	// fifo ready pins
	output logic      [1:0]  tx_ready_n,
	output logic      [1:0]  rx_ready_n
);
	localparam int BIT_CYC = CLK_HZ / BAUD_HZ; // clocks per bit, rounds down

	umpi_pkg::umpi_top_st_t         s_reg;   // current state
	umpi_pkg::umpi_top_st_t         s_next;  // next state
	umpi_pkg::umpi_chan_stat_t [1:0] stat;   // per channel status
	logic [1:0]                      tx_load; // write to transmit word
	logic [1:0]                      rx_pop;  // read of receive word
	logic [1:0]                      cts_block;
	logic [1:0]                      ser_in;
	logic [1:0]                      ser_out;
	logic [1:0]                      auto_rts;
	logic [1:0]                      auto_cts;
	logic [1:0]                      irq_src;
	logic                            ch;      // addressed channel
	logic [4:0]                      off;     // word offset inside channel
	logic                            hit;     // new request this cycle

	assign ser_in = {serial_in_ch_b, serial_in_ch_a};
	assign ch     = wb_adr_i[`UMPI_CH_SEL_BIT];
	assign off    = {wb_adr_i[4:2], 2'b00};

	// ==========================================================================
	// bus decode and control registers
	// ==========================================================================
	// ack one cycle after the strobe; writes land on the edge that raises ack
	always_comb begin
		s_next  = s_reg;
		tx_load = 2'b00;
		rx_pop  = 2'b00;
		hit     = wb_cyc_i && wb_stb_i && !s_reg.ack;
		s_next.ack = hit;
		s_next.dat = 32'h0000_0000;
		// addresses above the two channels ack with zero and drop writes
		if (hit && (wb_adr_i[`UMPI_UNMAPPED_MSB:6] == 2'b00)) begin
			if (wb_we_i && wb_sel_i[0]) begin
				case (off)
					// a write while the holding byte is full is refused
					`UMPI_OFF_TXD: tx_load[ch] = stat[ch].hold_empty;
					`UMPI_OFF_MCR: s_next.ctrl[ch].modem_control_reg = wb_dat_i[7:0];
					`UMPI_OFF_EFR: s_next.ctrl[ch].enhanced_feature_reg = wb_dat_i[7:0];
					`UMPI_OFF_IER: s_next.ctrl[ch].irq_enable_reg = wb_dat_i[7:0];
					default: begin
					end
				endcase
			end else if (!wb_we_i) begin
				case (off)
					`UMPI_OFF_RXD: begin
						s_next.dat = {24'h000000, stat[ch].rx_data};
						rx_pop[ch] = stat[ch].rx_valid;
					end
					`UMPI_OFF_MCR: s_next.dat = {24'h000000, s_reg.ctrl[ch].modem_control_reg};
					`UMPI_OFF_EFR: s_next.dat = {24'h000000, s_reg.ctrl[ch].enhanced_feature_reg};
					`UMPI_OFF_IER: s_next.dat = {24'h000000, s_reg.ctrl[ch].irq_enable_reg};
					`UMPI_OFF_STAT: begin
						// dsr, ri and cd are only reported here; cts is also acted on, gating transmit under auto cts
						s_next.dat[`UMPI_ST_CTS]      = !clear_to_send_n[ch];
						s_next.dat[`UMPI_ST_DSR]      = !data_set_ready_n[ch];
						s_next.dat[`UMPI_ST_RI]       = !ring_indicator_n[ch];
						s_next.dat[`UMPI_ST_CD]       = !carrier_detect_n[ch];
						s_next.dat[`UMPI_ST_RX_VALID] = stat[ch].rx_valid;
						s_next.dat[`UMPI_ST_TX_EMPTY] = stat[ch].hold_empty;
						s_next.dat[`UMPI_ST_TX_BUSY]  = stat[ch].tx_busy;
					end
					default: begin
					end
				endcase
			end
		end
	end

	// ==========================================================================
	// state register
	// ==========================================================================
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign wb_ack_o = s_reg.ack;
	assign wb_dat_o = s_reg.dat;

	// ==========================================================================
	// per channel pins
	// ==========================================================================
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_ch
			// both enable bits needed, so a half-set mode does nothing
			assign auto_rts[g] = s_reg.ctrl[g].enhanced_feature_reg[`UMPI_EFR_AUTO_RTS] && s_reg.ctrl[g].irq_enable_reg[`UMPI_IER_AUTO_RTS];
			assign auto_cts[g] = s_reg.ctrl[g].enhanced_feature_reg[`UMPI_EFR_AUTO_CTS] && s_reg.ctrl[g].irq_enable_reg[`UMPI_IER_AUTO_CTS];
			assign cts_block[g] = auto_cts[g] && clear_to_send_n[g];

			umpi_chan #(
				.BIT_CYC    (BIT_CYC)
			) u_chan (
				.sys_clk    (sys_clk),
				.rstn       (rstn),
				.tx_load    (tx_load[g]),
				.tx_data    (wb_dat_i[7:0]),
				.rx_pop     (rx_pop[g]),
				.cts_block  (cts_block[g]),
				.stat       (stat[g]),
				.serial_in  (ser_in[g]),
				.serial_out (ser_out[g])
			);

			// auto rts only withdraws an rts that software already raised
			assign request_to_send_n[g] = !(s_reg.ctrl[g].modem_control_reg[`UMPI_MCR_RTS] && !(auto_rts[g] && stat[g].rx_valid));
			assign terminal_ready_n[g]  = !s_reg.ctrl[g].modem_control_reg[`UMPI_MCR_DTR];
			assign tx_ready_n[g]        = !stat[g].hold_empty;
			assign rx_ready_n[g]        = !stat[g].rx_valid;
			assign irq_src[g] = (s_reg.ctrl[g].irq_enable_reg[`UMPI_IER_RX] && stat[g].rx_valid)
				|| (s_reg.ctrl[g].irq_enable_reg[`UMPI_IER_TX] && stat[g].hold_empty);
			// output select ties the irq driver and aux together
			assign channel_irq_oe[g]   = rstn && s_reg.ctrl[g].modem_control_reg[`UMPI_MCR_OUT_SEL];
			assign aux_output_two_n[g] = !channel_irq_oe[g];
			assign channel_irq[g]      = channel_irq_oe[g] && irq_src[g];

			// ==================================================================
			// checks
			// ==================================================================
			chk_irq_drive_sel: assert property (@(posedge sys_clk) disable iff (!rstn)
				s_reg.ctrl[g].modem_control_reg[`UMPI_MCR_OUT_SEL] |-> channel_irq_oe[g] && !aux_output_two_n[g])
				else $error("irq not driven with output select set");
			chk_irq_float_clr: assert property (@(posedge sys_clk) disable iff (!rstn)
				!s_reg.ctrl[g].modem_control_reg[`UMPI_MCR_OUT_SEL] |-> !channel_irq_oe[g] && aux_output_two_n[g])
				else $error("irq driven with output select clear");
			chk_cts_gate_start: assert property (@(posedge sys_clk) disable iff (!rstn)
				stat[g].tx_start && auto_cts[g] |-> !clear_to_send_n[g])
				else $error("character started while clear to send was high");
			chk_txrdy_after_load: assert property (@(posedge sys_clk) disable iff (!rstn)
				tx_load[g] |=> tx_ready_n[g] ##1 (tx_ready_n[g] || !stat[g].tx_busy || $past(stat[g].tx_start)))
				else $error("tx ready stayed low after load");
			chk_rxrdy_stop_high: assert property (@(posedge sys_clk) disable iff (!rstn)
				$fell(rx_ready_n[g]) |-> $past(ser_in[g]))
				else $error("rx ready fell without a high stop bit");
			chk_dtr_write: assert property (@(posedge sys_clk) disable iff (!rstn)
				tx_load[g] == 1'b0 && hit && wb_we_i && wb_sel_i[0] && ch == g && off == `UMPI_OFF_MCR
				&& wb_adr_i[7:6] == 2'b00 |=> terminal_ready_n[g] == !$past(wb_dat_i[`UMPI_MCR_DTR]))
				else $error("terminal ready did not follow write");
			chk_irq_high_level: assert property (@(posedge sys_clk) disable iff (!rstn)
				channel_irq_oe[g] && ((s_reg.ctrl[g].irq_enable_reg[`UMPI_IER_RX] && !rx_ready_n[g])
				|| (s_reg.ctrl[g].irq_enable_reg[`UMPI_IER_TX] && !tx_ready_n[g])) |-> channel_irq[g])
				else $error("driven irq not high");
			chk_reset_tx_high: assert property (@(posedge sys_clk)
				!rstn |=> ser_out[g] && aux_output_two_n[g] && !channel_irq_oe[g])
				else $error("outputs not in reset state");
			chk_tx_idle_rest: assert property (@(posedge sys_clk) disable iff (!rstn)
				!stat[g].tx_busy |-> ser_out[g])
				else $error("transmit line low while idle");
			chk_status_passive: assert property (@(posedge sys_clk) disable iff (!rstn)
				$changed(ring_indicator_n[g]) && !stat[g].tx_busy && !stat[g].tx_start |=> ser_out[g])
				else $error("status input disturbed transmit line");

			cov_tx_start: cover property (@(posedge sys_clk) disable iff (!rstn) stat[g].tx_start);
			cov_rx_byte: cover property (@(posedge sys_clk) disable iff (!rstn) $fell(rx_ready_n[g]));
			cov_irq_driven: cover property (@(posedge sys_clk) disable iff (!rstn) channel_irq[g]);
			cov_cts_hold: cover property (@(posedge sys_clk) disable iff (!rstn) cts_block[g] && !stat[g].hold_empty);
		end
	endgenerate

	// transmit lines held high while in reset
	assign serial_out_ch_a = !rstn || ser_out[0];
	assign serial_out_ch_b = !rstn || ser_out[1];
endmodule : umpi_top
`default_nettype wire

//--- umpi_regs.svh
// register offsets, field positions, reset values and timing for the modem pin block
`ifndef UMPI_REGS_SVH
`define UMPI_REGS_SVH

// ==========================================================================
// address map: bit 5 picks the channel, bits 4:2 the word inside it
// ==========================================================================
`define UMPI_CH_SEL_BIT     5
`define UMPI_UNMAPPED_MSB   7
`define UMPI_OFF_TXD        5'h00
`define UMPI_OFF_RXD        5'h04
`define UMPI_OFF_MCR        5'h08
`define UMPI_OFF_EFR        5'h0C
`define UMPI_OFF_IER        5'h10
`define UMPI_OFF_STAT       5'h14

// ==========================================================================
// modem control fields
// ==========================================================================
`define UMPI_MCR_DTR        0
`define UMPI_MCR_RTS        1
`define UMPI_MCR_OUT_SEL    3
`define UMPI_MCR_RST        8'h00

// ==========================================================================
// enhanced feature and irq enable fields
// ==========================================================================
`define UMPI_EFR_AUTO_RTS   6
`define UMPI_EFR_AUTO_CTS   7
`define UMPI_EFR_RST        8'h00
`define UMPI_IER_RX         0
`define UMPI_IER_TX         1
`define UMPI_IER_AUTO_RTS   6
`define UMPI_IER_AUTO_CTS   7
`define UMPI_IER_RST        8'h00

// ==========================================================================
// status word fields
// ==========================================================================
`define UMPI_ST_CTS         0
`define UMPI_ST_DSR         1
`define UMPI_ST_RI          2
`define UMPI_ST_CD          3
`define UMPI_ST_RX_VALID    4
`define UMPI_ST_TX_EMPTY    5
`define UMPI_ST_TX_BUSY     6

// ==========================================================================
// timing
// ==========================================================================
`define UMPI_CLK_HZ         10000000
`define UMPI_BAUD_HZ        115200

`endif

//--- umpi_pkg.sv
// types shared by the modem pin block
`default_nettype none
package umpi_pkg;
	// serial shifter phase
	typedef enum logic [1:0] {UMPI_IDLE, UMPI_START, UMPI_DATA, UMPI_STOP} umpi_phase_t;

	// whole state of one channel's shifters
	typedef struct packed {
		umpi_phase_t tx_ph;
		logic [15:0] tx_cnt;
		logic [2:0]  tx_bit;
		logic [7:0]  tx_sh;
		logic        hold_v;
		logic [7:0]  hold_d;
		logic        line;
		umpi_phase_t rx_ph;
		logic [15:0] rx_cnt;
		logic [2:0]  rx_bit;
		logic [7:0]  rx_sh;
		logic [7:0]  rx_d;
		logic        rx_v;
	} umpi_chan_st_t;

	// channel status back to the register side
	typedef struct packed {
		logic       tx_start;
		logic       tx_busy;
		logic       hold_empty;
		logic       rx_valid;
		logic [7:0] rx_data;
	} umpi_chan_stat_t;

	// software control bytes of one channel
	typedef struct packed {
		logic [7:0] modem_control_reg;
		logic [7:0] enhanced_feature_reg;
		logic [7:0] irq_enable_reg;
	} umpi_ctrl_t;

	// whole state of the top
	typedef struct packed {
		umpi_ctrl_t [1:0] ctrl;
		logic             ack;
		logic [31:0]      dat;
	} umpi_top_st_t;
endpackage : umpi_pkg
`default_nettype wire

//--- umpi_chan.sv
// one channel: holding register, transmit shifter and receive sampler, 8N1
`timescale 1ns/1ns
`default_nettype none
module umpi_chan #(
	parameter int BIT_CYC = 86
) (
	// clock and reset
	input  wire logic                      sys_clk,
	input  wire logic                      rstn,
	// register side
	input  wire logic                      tx_load,
	input  wire logic [7:0]                tx_data,
	input  wire logic                      rx_pop,
	input  wire logic                      cts_block,
	output umpi_pkg::umpi_chan_stat_t      stat,
	// pins
	input  wire logic                      serial_in,
	output logic                           serial_out
);
	localparam logic [15:0] BIT_M1  = 16'(BIT_CYC - 1);
	localparam logic [15:0] HALF_M1 = 16'((BIT_CYC / 2) - 1);

	umpi_pkg::umpi_chan_st_t s_reg;  // current state
	umpi_pkg::umpi_chan_st_t s_next; // next state
	logic                    start;  // holding byte moves to shifter

	// ==========================================================================
	// next state
	// ==========================================================================
	always_comb begin
		s_next = s_reg;
		start  = 1'b0;
		// load only lands in an empty holding register
		if (tx_load && !s_reg.hold_v) begin
			s_next.hold_v = 1'b1;
			s_next.hold_d = tx_data;
		end
		// transmitter
		case (s_reg.tx_ph)
			umpi_pkg::UMPI_IDLE: begin
				s_next.line = 1'b1;
				// a character already on the wire always finishes; cts only gates the next one
				if (s_reg.hold_v && !cts_block) begin
					start          = 1'b1;
					s_next.tx_sh   = s_reg.hold_d;
					s_next.hold_v  = 1'b0;
					s_next.tx_cnt  = 16'h0000;
					s_next.tx_ph   = umpi_pkg::UMPI_START;
					s_next.line    = 1'b0;
				end
			end
			umpi_pkg::UMPI_START: begin
				s_next.tx_cnt = s_reg.tx_cnt + 16'h0001;
				if (s_reg.tx_cnt == BIT_M1) begin
					s_next.tx_cnt = 16'h0000;
					s_next.tx_bit = 3'h0;
					s_next.tx_ph  = umpi_pkg::UMPI_DATA;
					s_next.line   = s_reg.tx_sh[0];
				end
			end
			umpi_pkg::UMPI_DATA: begin
				s_next.tx_cnt = s_reg.tx_cnt + 16'h0001;
				if (s_reg.tx_cnt == BIT_M1) begin
					s_next.tx_cnt = 16'h0000;
					if (s_reg.tx_bit == 3'h7) begin
						s_next.tx_ph = umpi_pkg::UMPI_STOP;
						s_next.line  = 1'b1;
					end else begin
						s_next.tx_bit = s_reg.tx_bit + 3'h1;
						s_next.tx_sh  = {1'b0, s_reg.tx_sh[7:1]};
						s_next.line   = s_reg.tx_sh[1];
					end
				end
			end
			umpi_pkg::UMPI_STOP: begin
				s_next.tx_cnt = s_reg.tx_cnt + 16'h0001;
				if (s_reg.tx_cnt == BIT_M1) begin
					s_next.tx_ph = umpi_pkg::UMPI_IDLE;
				end
			end
			default: begin
				s_next.tx_ph = umpi_pkg::UMPI_IDLE;
				s_next.line  = 1'b1;
			end
		endcase
		// pop first so a character arriving in the same cycle wins
		if (rx_pop) begin
			s_next.rx_v = 1'b0;
		end
		// receiver, sampling at mid bit
		case (s_reg.rx_ph)
			umpi_pkg::UMPI_IDLE: begin
				s_next.rx_cnt = 16'h0000;
				if (!serial_in) begin
					s_next.rx_ph = umpi_pkg::UMPI_START;
				end
			end
			umpi_pkg::UMPI_START: begin
				s_next.rx_cnt = s_reg.rx_cnt + 16'h0001;
				if (s_reg.rx_cnt == HALF_M1) begin
					s_next.rx_cnt = 16'h0000;
					s_next.rx_bit = 3'h0;
					// a glitch shorter than half a bit is not a start
					s_next.rx_ph  = serial_in ? umpi_pkg::UMPI_IDLE : umpi_pkg::UMPI_DATA;
				end
			end
			umpi_pkg::UMPI_DATA: begin
				s_next.rx_cnt = s_reg.rx_cnt + 16'h0001;
				if (s_reg.rx_cnt == BIT_M1) begin
					s_next.rx_cnt = 16'h0000;
					s_next.rx_sh  = {serial_in, s_reg.rx_sh[7:1]};
					s_next.rx_bit = s_reg.rx_bit + 3'h1;
					if (s_reg.rx_bit == 3'h7) begin
						s_next.rx_ph = umpi_pkg::UMPI_STOP;
					end
				end
			end
			umpi_pkg::UMPI_STOP: begin
				s_next.rx_cnt = s_reg.rx_cnt + 16'h0001;
				if (s_reg.rx_cnt == BIT_M1) begin
					s_next.rx_ph = umpi_pkg::UMPI_IDLE;
					// a low stop bit is a framing fault; the byte is dropped
					if (serial_in) begin
						s_next.rx_d = s_reg.rx_sh;
						s_next.rx_v = 1'b1;
					end
				end
			end
			default: begin
				s_next.rx_ph = umpi_pkg::UMPI_IDLE;
			end
		endcase
	end

	// ==========================================================================
	// state register; line rests high from reset
	// ==========================================================================
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			s_reg      <= '0;
			s_reg.line <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end

	// status out
	assign stat.tx_start   = start;
	assign stat.tx_busy    = (s_reg.tx_ph != umpi_pkg::UMPI_IDLE);
	assign stat.hold_empty = !s_reg.hold_v;
	assign stat.rx_valid   = s_reg.rx_v;
	assign stat.rx_data    = s_reg.rx_d;
	assign serial_out      = s_reg.line;
endmodule : umpi_chan
`default_nettype wire

//--- umpi_peer.sv
// serial peer model for one channel: sends and captures 8N1 characters
`timescale 1ns/1ns
`default_nettype none
module umpi_peer #(
	parameter int BIT_CYC = 8
) (
	// clock
	input  wire logic sys_clk,
	// serial lines
	input  wire logic line_from_dut,
	output logic      line_to_dut
);
	logic [7:0] got_byte; // last character captured
	int         got_cnt;  // characters captured so far
	initial begin
		line_to_dut = 1'b1; // line rests at mark
		got_byte = 8'h00;
		got_cnt = 0;
	end
	// ==========================================================================
	// transmit side
	// ==========================================================================
	// one character, lsb first; line goes back to mark after the stop bit
	task automatic send_byte(input logic [7:0] b);
		@(posedge sys_clk);
		line_to_dut <= 1'b0;
		repeat (BIT_CYC) @(posedge sys_clk);
		for (int i = 0; i < 8; i++) begin
			line_to_dut <= b[i];
			repeat (BIT_CYC) @(posedge sys_clk);
		end
		line_to_dut <= 1'b1; // stop bit, then idle high
		repeat (BIT_CYC) @(posedge sys_clk);
	endtask : send_byte
	// ==========================================================================
	// capture side
	// ==========================================================================
	// samples mid-bit; a low stop bit drops the character, like a real peer
	always begin : capture
		logic [7:0] d;
		@(negedge line_from_dut);
		repeat (BIT_CYC / 2) @(posedge sys_clk);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_CYC) @(posedge sys_clk);
			d[i] = line_from_dut;
		end
		repeat (BIT_CYC) @(posedge sys_clk);
		if (line_from_dut === 1'b1) begin
			got_byte = d;
			got_cnt++;
		end
	end
endmodule : umpi_peer
`default_nettype wire

//--- umpi_top_test.sv
// self-checking bench for the modem pin block: register tasks, pins, serial peers
`timescale 1ns/1ns
`default_nettype none
`include "umpi_regs.svh"
module umpi_top_test;
	localparam int BIT = 8; // short bit time keeps the run brief
	logic        sys_clk, rstn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [7:0]  wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, rd;
	logic        sin_a, sin_b, sout_a, sout_b;
	logic [1:0]  rts_n, cts_n, dtr_n, dsr_n, cd_n, ri_n, aux_n, irq, irq_oe, txr_n, rxr_n;
	int          err_count, n_checks, cyc_cnt;
	// ==========================================================================
	// design and peers
	// ==========================================================================
	umpi_top #(.CLK_HZ(10000000), .BAUD_HZ(10000000 / BIT)) dut_u (.sys_clk(sys_clk), .rstn(rstn),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .serial_in_ch_a(sin_a),
		.serial_in_ch_b(sin_b), .serial_out_ch_a(sout_a), .serial_out_ch_b(sout_b), .request_to_send_n(rts_n),
		.clear_to_send_n(cts_n), .terminal_ready_n(dtr_n), .data_set_ready_n(dsr_n), .carrier_detect_n(cd_n),
		.ring_indicator_n(ri_n), .aux_output_two_n(aux_n), .channel_irq(irq), .channel_irq_oe(irq_oe),
		.tx_ready_n(txr_n), .rx_ready_n(rxr_n));
	umpi_peer #(.BIT_CYC(BIT)) peer_a (.sys_clk(sys_clk), .line_from_dut(sout_a), .line_to_dut(sin_a));
	umpi_peer #(.BIT_CYC(BIT)) peer_b (.sys_clk(sys_clk), .line_from_dut(sout_b), .line_to_dut(sin_b));
	// ==========================================================================
	// helpers
	// ==========================================================================
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	// hang guard: a full run needs well under this many cycles
	always @(posedge sys_clk) begin
		cyc_cnt++;
		if (cyc_cnt == 20000) begin
			err_count++;
			tally_and_finish();
		end
	end
	// all non-bus output pins packed into one word so a single compare sees them all
	function automatic logic [31:0] pins();
		return {16'h0000, sout_a, sout_b, aux_n, irq_oe, irq, txr_n, rxr_n, rts_n, dtr_n};
	endfunction : pins
	function automatic logic [7:0] ra(input logic ch, input logic [4:0] off);
		return {2'b00, ch, off};
	endfunction : ra
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected %s: expected %h seen %h", name, exp, seen);
		end
	endtask : check
	// classic single cycle; waits for ack with no assumed latency
	task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge sys_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= adr;
		wb_sel_i <= 4'hF;
		wb_dat_i <= {24'h000000, d};
		do begin
			@(posedge sys_clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		if (n >= 50) begin
			err_count++;
			$display("unexpected ack: none within 50 cycles");
		end
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask : wb_xfer
	// bounded wait for a peer to capture a character
	task automatic wait_cnt(input logic ch, input int target);
		int n;
		n = 0;
		while ((ch ? peer_b.got_cnt : peer_a.got_cnt) < target && n < 400) begin
			@(posedge sys_clk);
			n++;
		end
		@(negedge sys_clk);
	endtask : wait_cnt
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : tally_and_finish
	// ==========================================================================
	// main sequence
	// ==========================================================================
	initial begin
		{rstn, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
		{cts_n, dsr_n, cd_n, ri_n} = 8'hFF; // modem inputs start inactive until a test drives them
		{err_count, n_checks, cyc_cnt} = '0;
		repeat (5) @(posedge sys_clk);
		rstn <= 1'b1;
		@(negedge sys_clk);
		check("pins after reset", pins(), 32'h0000F03F);
		$display("test reset done");
		// control bits: terminal ready, rts, output select on both channels
		for (int ch = 0; ch < 2; ch++) begin
			wb_xfer(1'b1, ra(ch[0], `UMPI_OFF_MCR), 8'h0B);
		end
		@(negedge sys_clk);
		check("pins mcr set", pins(), 32'h0000CC30);
		wb_xfer(1'b0, ra(1'b0, `UMPI_OFF_MCR), 8'h00);
		check("mcr readback", rd, 32'h0000000B);
		wb_xfer(1'b1, ra(1'b0, `UMPI_OFF_IER), 8'h02);
		@(negedge sys_clk);
		check("pins irq driven", pins(), 32'h0000CD30);
		wb_xfer(1'b1, ra(1'b0, `UMPI_OFF_MCR), 8'h03);
		@(negedge sys_clk);
		check("pins irq floated", pins(), 32'h0000D830);
		$display("test modem control done");
		// receive with rx irq and auto rts; rts already asserted first
		wb_xfer(1'b1, ra(1'b0, `UMPI_OFF_MCR), 8'h0B);
		wb_xfer(1'b1, ra(1'b0, `UMPI_OFF_EFR), 8'h40);
		wb_xfer(1'b1, ra(1'b0, `UMPI_OFF_IER), 8'h41);
		peer_a.send_byte(8'h3C);
		@(negedge sys_clk);
		check("pins byte waiting", pins(), 32'h0000CD24);
		wb_xfer(1'b0, ra(1'b0, `UMPI_OFF_STAT), 8'h00);
		check("stat rx valid", {25'h0, rd[6:0]}, 32'h00000030);
		wb_xfer(1'b0, ra(1'b0, `UMPI_OFF_RXD), 8'h00);
		check("rx data", rd, 32'h0000003C);
		@(negedge sys_clk);
		check("pins after pop", pins(), 32'h0000CC30);
		$display("test receive done");
		// status-only inputs asserted: reported, transmit unaffected
		@(posedge sys_clk);
		{dsr_n[0], cd_n[0], ri_n[0]} <= 3'b000;
		wb_xfer(1'b0, ra(1'b0, `UMPI_OFF_STAT), 8'h00);
		check("stat modem", {28'h0, rd[3:0]}, 32'h0000000E);
		wb_xfer(1'b1, ra(1'b0, `UMPI_OFF_TXD), 8'hA5);
		wait_cnt(1'b0, 1);
		check("tx byte a", {24'h0, peer_a.got_byte}, 32'h000000A5);
		check("pins tx idle", pins(), 32'h0000CC30);
		@(posedge sys_clk);
		{dsr_n[0], cd_n[0], ri_n[0]} <= 3'b111;
		$display("test status inputs done");
		// auto cts holds the character until the peer clears
		wb_xfer(1'b1, ra(1'b1, `UMPI_OFF_EFR), 8'h80);
		wb_xfer(1'b1, ra(1'b1, `UMPI_OFF_IER), 8'h80);
		wb_xfer(1'b1, ra(1'b1, `UMPI_OFF_TXD), 8'h5A);
		repeat (4 * BIT) @(posedge sys_clk);
		@(negedge sys_clk);
		check("pins cts hold", pins(), 32'h0000CCB0);
		@(posedge sys_clk);
		cts_n[1] <= 1'b0;
		wait_cnt(1'b1, 1);
		check("tx byte b", {24'h0, peer_b.got_byte}, 32'h0000005A);
		$display("test flow control done");
		// unmapped and out-of-range addresses
		wb_xfer(1'b0, 8'h18, 8'h00);
		check("unmapped read", rd, 32'h00000000);
		wb_xfer(1'b0, 8'h88, 8'h00);
		check("high address read", rd, 32'h00000000);
		wb_xfer(1'b1, 8'h88, 8'h00);
		@(negedge sys_clk);
		check("pins after ignored write", pins(), 32'h0000CC30);
		$display("test address map done");
		// reset in mid-character forces the line high
		wb_xfer(1'b1, ra(1'b0, `UMPI_OFF_TXD), 8'h00);
		repeat (3) @(posedge sys_clk);
		rstn <= 1'b0;
		repeat (2) @(posedge sys_clk);
		@(negedge sys_clk);
		check("pins mid reset", pins(), 32'h0000F03F);
		// pins only change on the rising edge, like every other stimulus
		@(posedge sys_clk);
		rstn <= 1'b1;
		// first access after release: control byte is back at its reset value
		wb_xfer(1'b0, ra(1'b0, `UMPI_OFF_MCR), 8'h00);
		check("mcr after reset", rd, {24'h000000, `UMPI_MCR_RST});
		$display("test mid reset done");
		tally_and_finish();
	end
endmodule : umpi_top_test
`default_nettype wire
